// ---- design/srl_map.svh ----
`ifndef SRL_MAP_SVH
`define SRL_MAP_SVH

// Command opcodes taken from the serial input
`define SRL_OP_ERASE 8'h44
`define SRL_OP_PROG 8'h42
`define SRL_OP_READ 8'h48
`define SRL_OP_LOCK 8'h36
`define SRL_OP_UNLOCK 8'h39
`define SRL_OP_RDLOCK 8'h3d

// Byte positions within a frame
`define SRL_IDX_OPCODE 3'd0
`define SRL_IDX_LAST_ADDR 3'd3
`define SRL_IDX_HDR_DONE 3'd4
`define SRL_IDX_SAT 3'd5
`define SRL_BIT_BOUNDARY 3'd0
`define SRL_BIT_FIRST 3'd1

// Region address decode
`define SRL_ADDR_HIGH_ZERO 8'h00
`define SRL_ADDR_MID_ZERO 4'h0
`define SRL_RGN_NONE 2'd0
`define SRL_RGN_FIRST 2'd1
`define SRL_RGN_LAST 2'd3
`define SRL_ERASED 8'hff
`define SRL_REGION_BYTES 768
`define SRL_ERASE_WRITES 32'h0000_0100

// Block and sector lock layout
`define SRL_LOCK_BITS 158
`define SRL_TOP_BLOCK 7'h7f
`define SRL_BOTTOM_BLOCK 7'h00
`define SRL_BOTTOM_SECT 4'h0
`define SRL_TOP_SECT 4'h1
`define SRL_BLOCK_BASE 8'd31

// Timing
`define SRL_CLK_MHZ 200
`define SRL_ERASE_US 100

`endif

// ---- design/srl_pkg.sv ----
package srl_pkg;

    // Region number, zero when the address selects none
    typedef logic [1:0] srl_region_t;

    // Whole state of the system-clock side
    typedef struct packed {
        logic cs_meta;                // Chip select, first sync stage
        logic cs_sync;                // Chip select, second sync stage
        logic cs_prev;                // Chip select, previous synced value
        logic tg_meta;                // Byte toggle, first sync stage
        logic tg_sync;                // Byte toggle, second sync stage
        logic tg_prev;                // Byte toggle, previous synced value
        logic [2:0] bits_meta;        // Link bit count, first sync stage
        logic [2:0] bits_sync;        // Link bit count, second sync stage
        logic [2:0] byte_cnt;         // Completed bytes in this frame
        logic [7:0] opcode;           // Captured opcode
        logic [23:0] addr;            // Captured address, low byte walks
        logic rd_ok;                  // Region read accepted
        logic prog_ok;                // Region program accepted
        logic [7:0] tx_byte;          // Next byte for the serial output
        logic tx_en;                  // Serial output driven
        logic busy;                   // Region erase running
        srl_region_t erase_region;    // Region being erased
        logic [31:0] erase_cnt;       // Erase cycle counter
        logic wel_clr;                // Write latch clear pulse
        logic [157:0] locks;          // Volatile block and sector locks
        logic query_prot;             // Registered protection answer
    } srl_state_t;

endpackage : srl_pkg

// ---- design/srl_security_lock.sv ----
// What this block does
// RULE1 - Three separate 256-byte regions, erased independently
// RULE2 - Region erase accepted only with write latch set
// RULE3 - Host sends erase opcode then 24-bit address
// RULE4 - Address bits 15..12 pick region, rest zero; the code does not check bits 7..0
// RULE5 - Erase runs only if select rises on byte boundary
// RULE6 - Self-timed erase reports busy until done
// RULE7 - Erase completion clears the write latch flag
// RULE8 - Locked region ignores erase commands
// RULE9 - Program needs write latch, opcode, address, data
// RULE10 - Program writes up to 256 bytes, bits only clear
// RULE11 - Locked region ignores program commands
// RULE12 - Read takes opcode, address, eight dummy clocks
// RULE13 - Read data leaves MSB first on falling edges
// RULE14 - Read address wraps within region after FFh
// RULE15 - Region read ignored while any cycle busy
// RULE16 - Locks protect only when scheme select is set
// RULE17 - Volatile locks come up set after reset
// RULE18 - Lock command sets one lock with write latch
// RULE19 - Unlock command clears one lock with write latch
// RULE20 - Lock readback shifts lock value, LSB meaning
// RULE21 - Host shifts bits MSB first on rising edges
`timescale 1ns/100ps
`include "srl_map.svh"

module srl_security_lock
    import srl_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = `SRL_ERASE_US * `SRL_CLK_MHZ
)
(
    // System clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Serial link from the host
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic serial_input_pin,
    output logic serial_out,
    output logic serial_out_oe_n,
    // Status bits held outside this block
    input wire logic write_latch_flag,
    input wire logic other_cycle_busy,
    input wire logic [2:0] region_otp_lock_bits,
    input wire logic protect_scheme_select,
    input wire logic range_protected,
    // Status produced by this block
    output logic busy_flag,
    output logic write_latch_clear,
    // Array protection query
    input wire logic [23:0] query_addr,
    output logic query_protected
);

    // Region from an address, none when the pattern does not match
    function automatic srl_region_t region_of(input logic [23:0] a);
        region_of = `SRL_RGN_NONE;
        if (a[23:16] == `SRL_ADDR_HIGH_ZERO && a[11:8] == `SRL_ADDR_MID_ZERO &&
            a[13:12] != `SRL_RGN_NONE && a[15:14] == `SRL_RGN_NONE)
            region_of = a[13:12]; // see RULE4
    endfunction : region_of

    // One-time lock of a region
    function automatic logic otp_of(input srl_region_t r, input logic [2:0] otp);
        otp_of = (r == `SRL_RGN_NONE) ? 1'b0 : otp[2'(r - `SRL_RGN_FIRST)];
    endfunction : otp_of

    // Memory word index from region and byte offset
    function automatic logic [9:0] mem_index(input srl_region_t r, input logic [7:0] off);
        mem_index = {2'(r - `SRL_RGN_FIRST), off}; // see RULE1
    endfunction : mem_index

    // Lock bit index: sectors in bottom and top block, blocks elsewhere
    function automatic logic [7:0] lock_index(input logic [23:0] a);
        lock_index = 8'(a[22:16]) + `SRL_BLOCK_BASE;
        if (a[22:16] == `SRL_BOTTOM_BLOCK)
            lock_index = {`SRL_BOTTOM_SECT, a[15:12]};
        else if (a[22:16] == `SRL_TOP_BLOCK)
            lock_index = {`SRL_TOP_SECT, a[15:12]};
    endfunction : lock_index

    // Link side registers
    logic armed_ff;           // Set while select is high, marks first edge
    logic [2:0] bit_cnt_ff;   // Bits of the current byte
    logic [7:0] rx_sh_ff;     // Input shifter
    logic [7:0] rx_byte_ff;   // Last complete byte, held for the crossing
    logic rx_tgl_ff;          // Flips once per complete byte
    logic [7:0] tx_sh_ff;     // Output shifter on falling edges
    logic [2:0] nxt_bit_cnt;  // Next bit count

    // System side state and memory
    srl_state_t state_ff;     // Registered state
    srl_state_t nxt_state;    // Next state
    logic [7:0] mem [0:`SRL_REGION_BYTES-1]; // Three regions back to back
    logic mem_we;             // Memory write strobe
    logic [9:0] mem_waddr;    // Memory write index
    logic [7:0] mem_wdata;    // Memory write data

    // First edge of a frame follows select being high
    always_ff @(posedge spi_clk or posedge cs_n)
    begin
        if (cs_n)
            armed_ff <= 1'b1;
        else
            armed_ff <= 1'b0;
    end

    // Bit count restarts on the first edge of a frame
    assign nxt_bit_cnt = armed_ff ? `SRL_BIT_FIRST : 3'(bit_cnt_ff + `SRL_BIT_FIRST);

    // Input shifting on rising edges, MSB first
    always_ff @(posedge spi_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_cnt_ff <= `SRL_BIT_BOUNDARY;
            rx_sh_ff <= 8'h00;
            rx_byte_ff <= 8'h00;
            rx_tgl_ff <= 1'b0;
        end
        else
        begin
            bit_cnt_ff <= nxt_bit_cnt;
            rx_sh_ff <= {rx_sh_ff[6:0], serial_input_pin}; // see RULE21
            // Whole byte: hold it and signal the other side
            if (nxt_bit_cnt == `SRL_BIT_BOUNDARY)
            begin
                rx_byte_ff <= {rx_sh_ff[6:0], serial_input_pin}; // see RULE12
                rx_tgl_ff <= ~rx_tgl_ff;
            end
        end
    end

    // Output shifting on falling edges, new byte at each boundary
    always_ff @(negedge spi_clk or negedge arst_n)
    begin
        if (!arst_n)
            tx_sh_ff <= 8'h00;
        else if (bit_cnt_ff == `SRL_BIT_BOUNDARY)
            tx_sh_ff <= state_ff.tx_byte; // see RULE13
        else
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end

    // Pin drivers
    assign serial_out = tx_sh_ff[7]; // see RULE13
    assign serial_out_oe_n = cs_n | ~state_ff.tx_en;
    assign busy_flag = state_ff.busy;
    assign write_latch_clear = state_ff.wel_clr;
    assign query_protected = state_ff.query_prot;

    // Next state of the system side
    always_comb
    begin
        logic frame_start;
        logic frame_end;
        logic byte_evt;
        logic busy_any;
        logic [2:0] k;
        srl_region_t rgn;
        frame_start = 1'b0;
        frame_end = 1'b0;
        byte_evt = 1'b0;
        busy_any = 1'b0;
        k = `SRL_IDX_OPCODE;
        rgn = `SRL_RGN_NONE;
        nxt_state = state_ff;
        mem_we = 1'b0;
        mem_waddr = 10'h000;
        mem_wdata = 8'h00;
        // Synchronisers
        nxt_state.cs_meta = cs_n;
        nxt_state.cs_sync = state_ff.cs_meta;
        nxt_state.cs_prev = state_ff.cs_sync;
        nxt_state.tg_meta = rx_tgl_ff;
        nxt_state.tg_sync = state_ff.tg_meta;
        nxt_state.tg_prev = state_ff.tg_sync;
        nxt_state.bits_meta = bit_cnt_ff;
        nxt_state.bits_sync = state_ff.bits_meta;
        nxt_state.wel_clr = 1'b0;
        frame_start = state_ff.cs_prev & ~state_ff.cs_sync;
        frame_end = ~state_ff.cs_prev & state_ff.cs_sync;
        byte_evt = state_ff.tg_sync ^ state_ff.tg_prev;
        busy_any = state_ff.busy | other_cycle_busy;
        // Frame start clears the command context
        if (frame_start)
        begin
            nxt_state.byte_cnt = `SRL_IDX_OPCODE;
            nxt_state.rd_ok = 1'b0;
            nxt_state.prog_ok = 1'b0;
            nxt_state.tx_en = 1'b0;
        end
        // A complete byte arrived from the link
        if (byte_evt)
        begin
            k = state_ff.byte_cnt;
            if (k != `SRL_IDX_SAT)
                nxt_state.byte_cnt = 3'(k + `SRL_BIT_FIRST);
            if (k == `SRL_IDX_OPCODE)
                nxt_state.opcode = rx_byte_ff; // see RULE3
            else if (k <= `SRL_IDX_LAST_ADDR)
                nxt_state.addr = {state_ff.addr[15:0], rx_byte_ff}; // see RULE12
            rgn = region_of(nxt_state.addr);
            // Address complete: qualify read and program
            if (k == `SRL_IDX_LAST_ADDR)
            begin
                if (state_ff.opcode == `SRL_OP_READ && rgn != `SRL_RGN_NONE)
                    nxt_state.rd_ok = ~busy_any; // see RULE15
                if (state_ff.opcode == `SRL_OP_PROG && rgn != `SRL_RGN_NONE)
                    nxt_state.prog_ok = write_latch_flag & ~busy_any &
                                        ~otp_of(rgn, region_otp_lock_bits); // see RULE9 RULE11
            end
            // Lock readback repeats the addressed lock value
            if (k >= `SRL_IDX_LAST_ADDR && state_ff.opcode == `SRL_OP_RDLOCK && !busy_any)
            begin
                nxt_state.tx_byte = {7'h00, state_ff.locks[lock_index(nxt_state.addr)]}; // see RULE20
                nxt_state.tx_en = 1'b1;
            end
            // Dummy byte or data byte done: present the next data byte
            if (k >= `SRL_IDX_HDR_DONE && state_ff.rd_ok)
            begin
                nxt_state.tx_byte = mem[mem_index(rgn, state_ff.addr[7:0])]; // see RULE13
                nxt_state.tx_en = 1'b1;
                nxt_state.addr[7:0] = 8'(state_ff.addr[7:0] + 8'h01); // see RULE14
            end
            // Program data byte: bits can only go from one to zero
            if (k >= `SRL_IDX_HDR_DONE && state_ff.prog_ok)
            begin
                mem_we = 1'b1;
                mem_waddr = mem_index(rgn, state_ff.addr[7:0]);
                mem_wdata = mem[mem_waddr] & rx_byte_ff; // see RULE10
                nxt_state.addr[7:0] = 8'(state_ff.addr[7:0] + 8'h01); // see RULE10
            end
        end
        // Frame end: run the commands that act on select rising
        if (frame_end)
        begin
            rgn = region_of(nxt_state.addr);
            if (nxt_state.byte_cnt == `SRL_IDX_HDR_DONE &&
                state_ff.bits_sync == `SRL_BIT_BOUNDARY &&
                write_latch_flag && !busy_any) // see RULE2 RULE5
            begin
                // Start a self-timed region erase
                if (nxt_state.opcode == `SRL_OP_ERASE && rgn != `SRL_RGN_NONE &&
                    !otp_of(rgn, region_otp_lock_bits)) // see RULE8
                begin
                    nxt_state.busy = 1'b1; // see RULE6
                    nxt_state.erase_region = rgn;
                    nxt_state.erase_cnt = 32'h0000_0000;
                end
                // Individual lock and unlock
                if (nxt_state.opcode == `SRL_OP_LOCK)
                    nxt_state.locks[lock_index(nxt_state.addr)] = 1'b1; // see RULE18
                if (nxt_state.opcode == `SRL_OP_UNLOCK)
                    nxt_state.locks[lock_index(nxt_state.addr)] = 1'b0; // see RULE19
            end
            nxt_state.tx_en = 1'b0;
            nxt_state.rd_ok = 1'b0;
            nxt_state.prog_ok = 1'b0;
        end
        // Erase cycle: blank the region, then wait out the duration
        if (state_ff.busy)
        begin
            nxt_state.erase_cnt = state_ff.erase_cnt + 32'h0000_0001;
            if (state_ff.erase_cnt < `SRL_ERASE_WRITES)
            begin
                mem_we = 1'b1;
                mem_waddr = mem_index(state_ff.erase_region, state_ff.erase_cnt[7:0]);
                mem_wdata = `SRL_ERASED; // see RULE1
            end
            if (state_ff.erase_cnt == 32'(ERASE_CYCLES - 1))
            begin
                nxt_state.busy = 1'b0; // see RULE6
                nxt_state.wel_clr = 1'b1; // see RULE7
            end
        end
        // Protection answer by the selected scheme
        if (protect_scheme_select)
            nxt_state.query_prot = state_ff.locks[lock_index(query_addr)]; // see RULE16
        else
            nxt_state.query_prot = range_protected; // see RULE16
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= '0;
            state_ff.cs_meta <= 1'b1;
            state_ff.cs_sync <= 1'b1;
            state_ff.cs_prev <= 1'b1;
            state_ff.locks <= '1; // see RULE17
        end
        else
            state_ff <= nxt_state;
    end

    // Region storage, no reset
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
            mem[mem_waddr] <= mem_wdata;
    end

    // Checks on the system side
    a_erase_busy_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_ff.busy) |-> state_ff.busy [*8]) // see RULE6
        else $error("erase busy shorter than expected");

    a_erase_wel_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(state_ff.busy) |-> state_ff.wel_clr && !$past(state_ff.wel_clr)) // see RULE7
        else $error("write latch clear missing at erase end");

    a_erase_needs_wel: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_ff.busy) |-> $past(write_latch_flag)) // see RULE2
        else $error("erase started without write latch");

    a_erase_otp_lock: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_ff.busy) |->
            !otp_of(state_ff.erase_region, $past(region_otp_lock_bits))) // see RULE8
        else $error("erase started on a locked region");

    a_erase_boundary: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_ff.busy) |-> $past(state_ff.bits_sync) == `SRL_BIT_BOUNDARY) // see RULE5
        else $error("erase started off a byte boundary");

    a_prog_otp_lock: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_ff.prog_ok) |->
            !otp_of(region_of(state_ff.addr), $past(region_otp_lock_bits))) // see RULE11
        else $error("program accepted on a locked region");

    a_read_busy_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_ff.rd_ok) |-> !$past(state_ff.busy) && !$past(other_cycle_busy)) // see RULE15
        else $error("read accepted while busy");

    a_read_addr_wrap: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_ff.rd_ok && state_ff.addr[7:0] == 8'hff &&
         (state_ff.tg_sync ^ state_ff.tg_prev) &&
         state_ff.byte_cnt >= `SRL_IDX_HDR_DONE) |=> state_ff.addr[7:0] == 8'h00) // see RULE14
        else $error("read address did not wrap");

    a_lock_change_wel: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_ff.locks != $past(state_ff.locks)) |-> $past(write_latch_flag)) // see RULE18 RULE19
        else $error("lock bits changed without write latch");

    a_scheme_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(arst_n) && !$past(protect_scheme_select) |->
            query_protected == $past(range_protected)) // see RULE16
        else $error("range protection not followed");

    c_erase_done: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(state_ff.busy));

    c_read_data: cover property (@(posedge sys_clk) disable iff (!arst_n)
        state_ff.rd_ok && state_ff.tx_en);

    c_prog_write: cover property (@(posedge sys_clk) disable iff (!arst_n)
        state_ff.prog_ok && mem_we);

    c_unlock_done: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(state_ff.locks[0]));

endmodule : srl_security_lock

// ---- dv/srl_host_model.sv ----
`timescale 1ns/100ps

// Host side of the serial link, one frame per call
module srl_host_model (
    // Link pins
    output logic spi_clk,
    output logic cs_n,
    output logic serial_input_pin,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    // Read bits of the last frame that the device drove
    int drv_cnt = 0;

    // Link idle: clock low and still, deselected
    initial
    begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        serial_input_pin = 1'b0;
    end

    // Send nb bits of tx from the top, then clock nrd bytes into rx
    task automatic frame(input logic [63:0] tx, input int nb, input int nrd,
                         output logic [31:0] rx);
        logic b;
        rx = 32'h0;
        drv_cnt = 0;
        cs_n = 1'b0;
        #32;
        for (int i = 0; i < nb + nrd * 8; i++)
        begin
            // New bit while clock is low, MSB first
            if (i < nb)
                serial_input_pin = tx[63 - i];
            else
                serial_input_pin = ~serial_input_pin;
            #32 spi_clk = 1'b1;
            // Released line has no pull: it shows the inverse
            b = serial_out_oe_n ? ~serial_out : serial_out;
            if (i >= nb)
                rx = {rx[30:0], b};
            if (i >= nb && !serial_out_oe_n)
                drv_cnt++;
            #32 spi_clk = 1'b0;
        end
        // Deselect right after the last bit, line no longer holds data
        cs_n = 1'b1;
        serial_input_pin = ~serial_input_pin;
        #48;
    endtask : frame
endmodule : srl_host_model

// ---- dv/tb.sv ----
`timescale 1ns/100ps

module tb;
    // Clock, reset and link wires
    logic sys_clk, arst_n, spi_clk, cs_n, sdi, sdo, sdo_oe_n;
    // Status inputs and outputs
    logic wlf, ocb, pss, rp, busy_flag, wlc, query_protected;
    logic [2:0] otp;
    logic [23:0] query_addr;
    // Reference model state
    logic [7:0] mem [0:767];
    logic lk [0:157];
    int error_cnt = 0, samples_checked = 0, seed = 32'hf8de;
    logic [31:0] rx;
    logic [23:0] a;

    srl_security_lock #(.ERASE_CYCLES(300)) u_srl_security_lock (
        .sys_clk(sys_clk), .arst_n(arst_n), .spi_clk(spi_clk), .cs_n(cs_n),
        .serial_input_pin(sdi), .serial_out(sdo), .serial_out_oe_n(sdo_oe_n),
        .write_latch_flag(wlf), .other_cycle_busy(ocb), .region_otp_lock_bits(otp),
        .protect_scheme_select(pss), .range_protected(rp), .busy_flag(busy_flag),
        .write_latch_clear(wlc), .query_addr(query_addr), .query_protected(query_protected));

    srl_host_model u_srl_host_model (.spi_clk(spi_clk), .cs_n(cs_n),
        .serial_input_pin(sdi), .serial_out(sdo), .serial_out_oe_n(sdo_oe_n));

    // System clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            error_cnt++;
        end
    endtask : check

    // Step past an edge so its updates have landed
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    // Status inputs change on the clock edge
    task automatic setin(logic wl, logic [2:0] ob, logic oc);
        @(posedge sys_clk);
        wlf <= wl;
        otp <= ob;
        ocb <= oc;
    endtask : setin

    // Lock index: sectors of top and bottom block, blocks otherwise
    function automatic int lidx(logic [23:0] ad);
        if (ad[22:16] == 7'h00)
            return ad[15:12];
        if (ad[22:16] == 7'h7f)
            return 16 + ad[15:12];
        return 31 + ad[22:16];
    endfunction : lidx

    task automatic erase(logic [3:0] r, int cut, bit ok);
        int n;
        u_srl_host_model.frame({8'h44, 8'h00, r, 4'h0, 8'h5a, 32'h0}, 32 - cut, 0, rx);
        n = 0;
        while (busy_flag !== 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        check("busy", {7'h0, busy_flag}, {7'h0, ok});
        if (ok)
        begin
            while (busy_flag === 1'b1 && n < 400)
            begin
                cyc(1);
                n++;
            end
            if (n >= 400)
            begin
                error_cnt++;
                end_sim();
            end
            check("latch_clear", {7'h0, wlc}, 8'h01);
            for (int i = 0; i < 256; i++)
                mem[(r - 1) * 256 + i] = 8'hff;
        end
    endtask : erase

    task automatic prog(logic [3:0] r, logic [7:0] off, logic [23:0] d, bit ok);
        u_srl_host_model.frame({8'h42, 8'h00, r, 4'h0, off, d, 8'h0}, 56, 0, rx);
        for (int k = 0; k < 3 && ok; k++)
            mem[(r - 1) * 256 + ((off + k) % 256)] &= d[23 - 8 * k -: 8];
    endtask : prog

    // Three bytes from off, wrapping inside the region
    task automatic rd(logic [3:0] r, logic [7:0] off, bit ok);
        int base;
        base = (r - 1) * 256;
        u_srl_host_model.frame({8'h48, 8'h00, r, 4'h0, off, 8'h00, 24'h0}, 40, 3, rx);
        check("rd_drive", 8'(u_srl_host_model.drv_cnt), ok ? 8'd24 : 8'd0);
        for (int k = 0; k < 3 && ok; k++)
            check("rd", rx[23 - 8 * k -: 8], mem[base + (off + k) % 256]);
    endtask : rd

    // Lock state through readback and through the protection query
    task automatic lkchk(logic [23:0] ad);
        u_srl_host_model.frame({8'h3d, ad, 32'h0}, 32, 1, rx);
        check("rdlock", rx[7:0], {7'h0, lk[lidx(ad)]});
        @(posedge sys_clk);
        query_addr <= ad;
        pss <= 1'b1;
        rp <= 1'b0;
        cyc(2);
        check("prot", {7'h0, query_protected}, {7'h0, lk[lidx(ad)]});
        @(posedge sys_clk);
        pss <= 1'b0;
        rp <= 1'($random(seed));
        cyc(2);
        check("range", {7'h0, query_protected}, {7'h0, rp});
    endtask : lkchk

    // Hang guard
    initial
    begin
        #400us;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        arst_n = 1'b0;
        wlf = 1'b0;
        ocb = 1'b0;
        otp = 3'h0;
        pss = 1'b1;
        rp = 1'b0;
        query_addr = 24'h0;
        for (int i = 0; i < 158; i++)
            lk[i] = 1'b1;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        cyc(3);
        // Locks come up set
        for (int k = 0; k < 4; k++)
            lkchk({1'b0, 7'($random(seed)), 4'($random(seed)), 12'h0});
        // Unlock then lock, top and bottom sectors and random blocks
        for (int k = 0; k < 8; k++)
        begin
            a = {1'b0, 7'($random(seed)), 4'($random(seed)), 12'h0};
            if (k % 4 == 0)
                a[22:16] = 7'h00;
            if (k % 4 == 1)
                a[22:16] = 7'h7f;
            setin(k != 2 && k != 6, 3'h0, 1'b0);
            u_srl_host_model.frame({k < 4 ? 8'h39 : 8'h36, a, 32'h0}, 32, 0, rx);
            if (k != 2 && k != 6)
                lk[lidx(a)] = k >= 4;
            lkchk(a);
        end
        // Each region erased on its own
        setin(1'b1, 3'h0, 1'b0);
        for (int r = 1; r < 4; r++)
            erase(4'(r), 0, 1'b1);
        prog(4'h2, 8'hfe, 24'($random(seed)), 1'b1);
        prog(4'h2, 8'hff, 24'($random(seed)), 1'b1);
        prog(4'h3, 8'h10, 24'($random(seed)), 1'b1);
        rd(4'h2, 8'hfe, 1'b1);
        rd(4'h2, 8'hff, 1'b1);
        // Refused erases and programs
        setin(1'b0, 3'h0, 1'b0);
        prog(4'h3, 8'h10, 24'h0, 1'b0);
        erase(4'h2, 0, 1'b0);
        setin(1'b1, 3'h2, 1'b0);
        erase(4'h2, 0, 1'b0);
        prog(4'h2, 8'hfe, 24'h0, 1'b0);
        setin(1'b1, 3'h0, 1'b0);
        erase(4'h2, 1, 1'b0);
        erase(4'h2, -1, 1'b0);
        erase(4'h4, 0, 1'b0);
        rd(4'h2, 8'hfe, 1'b1);
        rd(4'h3, 8'h10, 1'b1);
        // Read ignored while another cycle runs
        setin(1'b1, 3'h0, 1'b1);
        rd(4'h2, 8'hfe, 1'b0);
        setin(1'b1, 3'h0, 1'b0);
        // Region two erased, region three keeps its data
        erase(4'h2, 0, 1'b1);
        rd(4'h2, 8'hff, 1'b1);
        rd(4'h3, 8'h10, 1'b1);
        // A reset in mid-run sets every lock again
        u_srl_host_model.frame({8'h39, 24'h0, 32'h0}, 32, 0, rx);
        lk[0] = 1'b0;
        lkchk(24'h0);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 158; i++)
            lk[i] = 1'b1;
        cyc(3);
        lkchk(24'h0);
        end_sim();
    end
endmodule : tb
